// ### logic/program_lock_verify_guard.sv
/*
 * program memory with encryption array and two lock cells, guarding
 * verify, programming and core table reads; wishbone slave for erase
 * and status.
 * assumes synchronous programmer pins and a classic wishbone master.
 */
// The address map and register access over Wishbone were left to the implementer.
// Operation
// RULE1 - 32-byte encryption array, every bit one when unprogrammed
// RULE2 - five address lines pick the encryption byte on verify
// RULE3 - verify output is code byte XNOR encryption byte
// RULE4 - all-ones encryption array returns the code unaltered
// RULE5 - programmer should set a lock bit when using encryption
// RULE6 - erase also clears encryption array and both lock bits
// RULE7 - both locks clear: no restrictions, verify still encrypted
// RULE8 - first lock only: external table reads of internal code blocked
// RULE9 - first lock: external-access pin latched at reset, held
// RULE10 - first lock: further code programming pulses rejected
// RULE11 - both locks: all above plus verify refused
// RULE12 - second lock alone is reserved, no defined protection
// RULE13 - system keeps external-access pin equal to latched level
// RULE14 - signature read as verify of 030H and 031H, selects low
// RULE15 - after erase every program memory cell reads one
// RULE16 - programmer drives address on low port and five upper pins
// RULE17 - programming uses 25 low strobe pulses of 100 us
// RULE18 - lock bits never readable through verify
// RULE19 - protection derived from lock cells before any access completes
`timescale 1ns/1ns
`default_nettype none
`include "plv_defs.svh"

module program_lock_verify_guard
   import plv_pkg::*;
#(
   parameter int CODE_DEPTH = `PLV_CODE_DEPTH,
   parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
   parameter logic [7:0] PART_CODE = 8'h3C // arbitrary value
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // programmer pins
   input wire program_pulse_strobe_pins_t program_pulse_strobe_pins_i,
   input wire logic [7:0] data_port_i,
   output logic [7:0] data_port_o,
   output logic data_port_oe_o,
   // core side
   input wire logic external_code_select_pin_n_i,
   output logic ext_code_select_n_o,
   input wire table_req_t table_req_i,
   output logic [7:0] table_data_o,
   output logic table_valid_o,
   output logic table_blocked_o
);

   localparam int AW = $clog2(CODE_DEPTH);

   // ==========================================================
   // parameter check
   generate
      if (CODE_DEPTH > `PLV_CODE_DEPTH || CODE_DEPTH < 64 ||
          (CODE_DEPTH & (CODE_DEPTH - 1)) != 0) begin : g_bad_depth
         $error("CODE_DEPTH must be a power of two from 64 to 8192");
      end
   endgenerate

   // ==========================================================
   // decode of the programmer pin levels
   function automatic op_mode_t decode_mode(input program_pulse_strobe_pins_t p);
      op_mode_t m;
      m = MODE_IDLE;
      if (!p.program_pulse_strobe_n || p.vpp_present) begin
         if (!p.enable_n) begin
            m = MODE_IDLE;
         end else if (!p.mode_sel && p.signature_select_a && p.signature_select_b) begin
            m = MODE_PROGRAM_PULSE_STROBE_CODE;
         end else if (!p.mode_sel && !p.signature_select_a && p.signature_select_b) begin
            m = MODE_PROGRAM_PULSE_STROBE_ENC;
         end else if (p.mode_sel && p.signature_select_a && p.signature_select_b) begin
            m = MODE_PROGRAM_PULSE_STROBE_LOCK1;
         end else if (p.mode_sel && !p.signature_select_a && !p.signature_select_b) begin
            m = MODE_PROGRAM_PULSE_STROBE_LOCK2;
         end
      end else if (!p.enable_n && !p.mode_sel) begin
         if (p.signature_select_a && p.signature_select_b) begin
            m = MODE_VERIFY;
         end else if (!p.signature_select_a && !p.signature_select_b) begin
            m = MODE_SIGNATURE;
         end
      end
      return m;
   endfunction

   // ==========================================================
   // nonvolatile storage
   // RULE1 unprogrammed encryption array
   // erased power-up contents; only the storage write block drives
   // these cells afterwards
   logic [7:0] code_mem [CODE_DEPTH] = '{default: `PLV_ERASED_BYTE};
   logic [7:0] enc_mem [`PLV_ENC_BYTES] = '{default: `PLV_ERASED_BYTE};
   logic lock_first_cell = `PLV_CELL_UNPROG;
   logic lock_second_cell = `PLV_CELL_UNPROG;

   // ==========================================================
   // protection state
   logic lock_level_first;
   logic lock_level_second;
   logic program_pulse_strobe_blocked;
   logic verify_blocked;
   logic table_guard;

   // RULE19 protection from lock cells
   assign lock_level_first = (lock_first_cell == `PLV_CELL_PROGRAM_PULSE_STROBE);
   assign lock_level_second = (lock_second_cell == `PLV_CELL_PROGRAM_PULSE_STROBE);
   // RULE7 RULE12 no restriction unless first set
   // RULE10 programming refused when locked, except the second lock cell
   assign program_pulse_strobe_blocked = lock_level_first;
   // RULE11 verify refused at both locks
   assign verify_blocked = lock_level_first && lock_level_second;
   // RULE8 table read guard
   assign table_guard = lock_level_first;

   // ==========================================================
   // pin decode and strobe edge
   op_mode_t mode;
   logic strobe_d;
   logic program_pulse_strobe_pulse;
   logic [`PLV_PIN_ADDR_W-1:0] pin_addr;
   logic [AW-1:0] code_idx;
   logic [`PLV_ENC_SEL_W-1:0] enc_sel;

   assign mode = decode_mode(program_pulse_strobe_pins_i);
   // RULE16 address from low port and upper pins
   assign pin_addr = {program_pulse_strobe_pins_i.upper_address_pins, program_pulse_strobe_pins_i.addr_low};
   assign code_idx = pin_addr[AW-1:0];
   // RULE2 five address lines select encryption byte
   assign enc_sel = pin_addr[`PLV_ENC_SEL_W-1:0];
   // RULE17 each low pulse of the strobe is one programming pulse
   assign program_pulse_strobe_pulse = strobe_d && !program_pulse_strobe_pins_i.program_pulse_strobe_n;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe_d <= 1'b1;
      end else begin
         strobe_d <= program_pulse_strobe_pins_i.program_pulse_strobe_n;
      end
   end

   // ==========================================================
   // erase sequencer
   erase_state_t state;
   logic [AW-1:0] erase_ptr;
   logic erase_req;
   logic busy;

   assign busy = (state == ST_ERASE);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         erase_ptr <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               erase_ptr <= '0;
               if (erase_req) begin
                  state <= ST_ERASE;
               end
            end
            ST_ERASE: begin
               erase_ptr <= erase_ptr + 1'b1;
               if (erase_ptr == AW'(CODE_DEPTH - 1)) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // storage writes: erase first, then programming pulses
   logic reject_evt;

   always_ff @(posedge clk_i) begin
      if (busy) begin
         // RULE15 erased cells read one
         code_mem[erase_ptr] <= `PLV_ERASED_BYTE;
         // RULE6 erase clears encryption and locks
         if (erase_ptr < AW'(`PLV_ENC_BYTES)) begin
            enc_mem[erase_ptr[`PLV_ENC_SEL_W-1:0]] <= `PLV_ERASED_BYTE;
         end
         lock_first_cell <= `PLV_CELL_UNPROG;
         lock_second_cell <= `PLV_CELL_UNPROG;
      end else if (program_pulse_strobe_pulse && !program_pulse_strobe_blocked) begin
         // programming only pulls bits to zero
         case (mode)
            MODE_PROGRAM_PULSE_STROBE_CODE: begin
               code_mem[code_idx] <= code_mem[code_idx] & data_port_i;
            end
            MODE_PROGRAM_PULSE_STROBE_ENC: begin
               if (pin_addr < `PLV_PIN_ADDR_W'(`PLV_ENC_BYTES)) begin
                  enc_mem[enc_sel] <= enc_mem[enc_sel] & data_port_i;
               end
            end
            MODE_PROGRAM_PULSE_STROBE_LOCK1: begin
               lock_first_cell <= `PLV_CELL_PROGRAM_PULSE_STROBE;
            end
            MODE_PROGRAM_PULSE_STROBE_LOCK2: begin
               lock_second_cell <= `PLV_CELL_PROGRAM_PULSE_STROBE;
            end
            default: begin
            end
         endcase
      end else if (program_pulse_strobe_pulse && mode == MODE_PROGRAM_PULSE_STROBE_LOCK2) begin
         lock_second_cell <= `PLV_CELL_PROGRAM_PULSE_STROBE;
      end
   end

   // RULE10 refused pulse or pulse during erase
   assign reject_evt = program_pulse_strobe_pulse && (busy ||
      (program_pulse_strobe_blocked && (mode == MODE_PROGRAM_PULSE_STROBE_CODE || mode == MODE_PROGRAM_PULSE_STROBE_ENC)));

   // ==========================================================
   // verify and signature read-out
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_port_o <= 8'h00;
         data_port_oe_o <= 1'b0;
      end else begin
         data_port_o <= 8'h00;
         data_port_oe_o <= 1'b0;
         if (!busy && mode == MODE_VERIFY && !verify_blocked) begin
            // RULE3 RULE4 XNOR with encryption byte
            // RULE18 lock cells never on the data port
            data_port_o <= code_mem[code_idx] ~^ enc_mem[enc_sel];
            data_port_oe_o <= 1'b1;
         end else if (!busy && mode == MODE_SIGNATURE) begin
            // RULE14 signature bytes
            data_port_oe_o <= 1'b1;
            if (pin_addr == `PLV_SIG_MAKER_ADDR) begin
               data_port_o <= MAKER_CODE;
            end else if (pin_addr == `PLV_SIG_PART_ADDR) begin
               data_port_o <= PART_CODE;
            end else begin
               data_port_o <= `PLV_ERASED_BYTE;
            end
         end
      end
   end

   // ==========================================================
   // external-access select latch
   logic ext_sel_latched;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // RULE9 sample pin during reset
         ext_sel_latched <= external_code_select_pin_n_i;
         ext_code_select_n_o <= external_code_select_pin_n_i;
      end else begin
         // RULE9 RULE13 locked part holds latched level
         ext_code_select_n_o <= lock_level_first ? ext_sel_latched
                                                 : external_code_select_pin_n_i;
      end
   end

   // ==========================================================
   // core table reads
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         table_data_o <= 8'h00;
         table_valid_o <= 1'b0;
         table_blocked_o <= 1'b0;
      end else begin
         table_valid_o <= table_req_i.req;
         table_blocked_o <= 1'b0;
         table_data_o <= table_data_o;
         if (table_req_i.req) begin
            // RULE8 no internal bytes for external code
            if (table_req_i.from_external && table_guard) begin
               table_blocked_o <= 1'b1;
               table_data_o <= `PLV_ERASED_BYTE;
            end else begin
               table_data_o <= code_mem[table_req_i.addr[AW-1:0]];
            end
         end
      end
   end

   // ==========================================================
   // wishbone slave
   logic wb_hit;
   logic wb_write;
   logic reject_flag;
   logic [31:0] next_rdata;

   assign wb_hit = wb_cyc_i && wb_stb_i;
   assign wb_write = wb_hit && wb_we_i && wb_ack_o && wb_sel_i[0];
   assign erase_req = wb_write && (wb_adr_i == `PLV_REG_CTRL) &&
                      wb_dat_i[`PLV_CTRL_ERASE_BIT];

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (wb_adr_i)
         `PLV_REG_STATUS: begin
            next_rdata[`PLV_STAT_BUSY_BIT] = busy;
            next_rdata[`PLV_STAT_EXT_SEL_BIT] = ext_sel_latched;
            next_rdata[`PLV_STAT_REJECT_BIT] = reject_flag;
            next_rdata[`PLV_STAT_BLOCKED_BIT] = table_blocked_o;
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_hit && !wb_ack_o;
         wb_dat_o <= next_rdata;
      end
   end

   // sticky reject flag, set wins over write-one clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reject_flag <= 1'b0;
      end else if (reject_evt) begin
         reject_flag <= 1'b1;
      end else if (wb_write && wb_adr_i == `PLV_REG_STATUS &&
                   wb_dat_i[`PLV_STAT_REJECT_BIT]) begin
         reject_flag <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ### shared/plv_defs.svh
/*
 * constants of the program lock and verify guard: sizes, addresses,
 * register offsets, bit positions and erased values.
 * assumes inclusion by bare name from the package and the design.
 */
`ifndef PLV_DEFS_SVH
`define PLV_DEFS_SVH

// ==========================================================
// memory geometry
`define PLV_CODE_DEPTH 8192
`define PLV_PIN_ADDR_W 13
`define PLV_ENC_BYTES 32
`define PLV_ENC_SEL_W 5
`define PLV_ERASED_BYTE 8'hFF
`define PLV_CELL_UNPROG 1'b1
`define PLV_CELL_PROGRAM_PULSE_STROBE 1'b0

// ==========================================================
// signature locations
`define PLV_SIG_MAKER_ADDR 13'h0030
`define PLV_SIG_PART_ADDR 13'h0031

// ==========================================================
// wishbone register map (byte offsets)
`define PLV_REG_CTRL 8'h00
`define PLV_REG_STATUS 8'h04
`define PLV_CTRL_ERASE_BIT 0
`define PLV_STAT_BUSY_BIT 0
`define PLV_STAT_EXT_SEL_BIT 1
`define PLV_STAT_REJECT_BIT 2
`define PLV_STAT_BLOCKED_BIT 3

`endif

// ### shared/plv_pkg.sv
/*
 * types of the program lock and verify guard.
 * assumes plv_defs.svh on the include path.
 */
`include "plv_defs.svh"

package plv_pkg;

   // ==========================================================
   // decoded programmer operation
   typedef enum logic [2:0] {
      MODE_IDLE = 3'b000,
      MODE_VERIFY = 3'b001,
      MODE_SIGNATURE = 3'b010,
      MODE_PROGRAM_PULSE_STROBE_CODE = 3'b011,
      MODE_PROGRAM_PULSE_STROBE_ENC = 3'b100,
      MODE_PROGRAM_PULSE_STROBE_LOCK1 = 3'b101,
      MODE_PROGRAM_PULSE_STROBE_LOCK2 = 3'b110
   } op_mode_t;

   // ==========================================================
   // erase sequencer
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_ERASE = 1'b1
   } erase_state_t;

   // ==========================================================
   // programmer-side pins
   typedef struct packed {
      logic [7:0] addr_low;
      logic [4:0] upper_address_pins;
      logic enable_n;
      logic mode_sel;
      logic signature_select_a;
      logic signature_select_b;
      logic program_pulse_strobe_n;
      logic vpp_present;
   } program_pulse_strobe_pins_t;

   // ==========================================================
   // core table-read request
   typedef struct packed {
      logic req;
      logic from_external;
      logic [`PLV_PIN_ADDR_W-1:0] addr;
   } table_req_t;

endpackage

// ### sim/plv_asserts.sv
/* checker of the program lock and verify guard.
   assumes binding to the top module, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module plv_asserts
   import plv_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
   parameter logic [7:0] PART_CODE = 8'h3C // arbitrary value
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // watched ports
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire program_pulse_strobe_pins_t program_pulse_strobe_pins_i,
   input wire logic [7:0] data_port_o,
   input wire logic data_port_oe_o,
   input wire table_req_t table_req_i,
   input wire logic [7:0] table_data_o,
   input wire logic table_valid_o,
   input wire logic table_blocked_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic rd_mode;
   logic sig_mode;
   logic [12:0] pa;
   assign pa = {program_pulse_strobe_pins_i.upper_address_pins, program_pulse_strobe_pins_i.addr_low};
   assign rd_mode = program_pulse_strobe_pins_i.program_pulse_strobe_n && !program_pulse_strobe_pins_i.vpp_present
      && !program_pulse_strobe_pins_i.enable_n && !program_pulse_strobe_pins_i.mode_sel
      && (program_pulse_strobe_pins_i.signature_select_a == program_pulse_strobe_pins_i.signature_select_b);
   assign sig_mode = rd_mode && !program_pulse_strobe_pins_i.signature_select_a;
   // ==========================================================
   // assertions
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_timely: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
      else $error("ack late");
   a_sig_maker: assert property (
      sig_mode && pa == 13'h0030 |=> !data_port_oe_o || data_port_o == MAKER_CODE)
      else $error("maker byte wrong");
   a_sig_part: assert property (
      sig_mode && pa == 13'h0031 |=> !data_port_oe_o || data_port_o == PART_CODE)
      else $error("part byte wrong");
   a_oe_cause: assert property (data_port_oe_o |-> $past(rd_mode))
      else $error("data port driven outside read");
   a_data_steady: assert property (data_port_oe_o && $past(data_port_oe_o)
      && !$past(wb_cyc_i, 2) && $past(program_pulse_strobe_pins_i) == $past(program_pulse_strobe_pins_i, 2)
      |-> $stable(data_port_o))
      else $error("verify byte moved");
   a_valid_next: assert property (table_req_i.req |=> table_valid_o)
      else $error("table answer missing");
   a_blocked_ff: assert property (
      table_blocked_o |-> table_valid_o && table_data_o == 8'hFF)
      else $error("blocked read leaks data");
   a_internal_free: assert property (
      table_req_i.req && !table_req_i.from_external |=> !table_blocked_o)
      else $error("internal read blocked");
   c_sig: cover property (sig_mode && pa == 13'h0030);
   c_block: cover property (table_blocked_o);
   c_verify: cover property (data_port_oe_o && !sig_mode);
endmodule
`default_nettype wire

// ### sim/plv_programmer.sv
/* programmer model driving the programming pins and data port.
   assumes the bench calls its tasks; pulses shortened. */
`timescale 1ns/1ns
`default_nettype none
module plv_programmer
   import plv_pkg::*;
#(
   parameter int PULSE_CYCLES = 4
) (
   // clock
   input wire logic clk_i,
   // pins
   output program_pulse_strobe_pins_t pins_o,
   output logic [7:0] data_o
);
   initial begin
      pins_o = '0;
      pins_o.enable_n = 1'b1;
      pins_o.program_pulse_strobe_n = 1'b1;
      data_o = 8'h00;
   end
   // released port shows the inverse of the last byte
   task automatic idle();
      @(posedge clk_i);
      pins_o.enable_n <= 1'b1;
      pins_o.vpp_present <= 1'b0;
      data_o <= ~data_o;
   endtask
   // address on low and upper pins
   task automatic rd(input logic sig, input logic [12:0] a);
      @(posedge clk_i);
      pins_o <= {a[7:0], a[12:8], 1'b0, 1'b0, ~sig, ~sig, 1'b1, 1'b0};
   endtask
   task automatic program_pulse_strobe(input logic [1:0] k, input logic [12:0] a, input logic [7:0] d);
      logic ms;
      logic sa;
      logic sb;
      ms = k[1];
      sa = (k == 2'd0 || k == 2'd2);
      sb = (k != 2'd3);
      @(posedge clk_i);
      pins_o <= {a[7:0], a[12:8], 1'b1, ms, sa, sb, 1'b1, 1'b1};
      data_o <= d;
      repeat (25) begin
         repeat (PULSE_CYCLES) @(posedge clk_i);
         pins_o.program_pulse_strobe_n <= 1'b0;
         repeat (PULSE_CYCLES) @(posedge clk_i);
         pins_o.program_pulse_strobe_n <= 1'b1;
      end
      idle();
   endtask
endmodule
`default_nettype wire

// ### sim/program_lock_verify_guard_bench.sv
/* bench of the program lock and verify guard.
   assumes checker and programmer model compiled before it. */
`timescale 1ns/1ns
`default_nettype none
`include "plv_defs.svh"
module program_lock_verify_guard_bench
   import plv_pkg::*;
;
   // signature values are arbitrary
   localparam logic [7:0] MAKER = 8'h5A;
   localparam logic [7:0] PART = 8'hC3;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic ext_sel_n = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   table_req_t treq = '0;
   program_pulse_strobe_pins_t pins;
   logic [7:0] pdat;
   logic [31:0] wb_dat;
   logic [7:0] dout;
   logic [7:0] tdata;
   logic ack, oe, ext_sel_o, tvalid, tblocked;
   int failures = 0;
   int comparisons = 0;
   always #2 clk_i = ~clk_i;
   program_lock_verify_guard #(.CODE_DEPTH(64), .MAKER_CODE(MAKER), .PART_CODE(PART)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(ack),
      .program_pulse_strobe_pins_i(pins), .data_port_i(pdat), .data_port_o(dout), .data_port_oe_o(oe),
      .external_code_select_pin_n_i(ext_sel_n), .ext_code_select_n_o(ext_sel_o),
      .table_req_i(treq), .table_data_o(tdata), .table_valid_o(tvalid),
      .table_blocked_o(tblocked));
   plv_programmer program_pulse_strobe (.clk_i(clk_i), .pins_o(pins), .data_o(pdat));
   // ==========================================================
   // helpers
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = wb_dat;
      cyc <= 1'b0;
   endtask
   task automatic erase();
      logic [31:0] q;
      wb(1'b1, `PLV_REG_CTRL, 32'h1, q);
      do wb(1'b0, `PLV_REG_STATUS, 32'h0, q); while (q[0] === 1'b1);
   endtask
   task automatic reset_dut(input logic sel_n);
      @(posedge clk_i);
      rst_i <= 1'b1;
      ext_sel_n <= sel_n;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   task automatic vchk(input logic sig, input logic [12:0] a, input logic e_oe,
         input logic [7:0] e_d);
      program_pulse_strobe.rd(sig, a);
      repeat (2) @(negedge clk_i);
      chk("oe", oe, e_oe);
      if (e_oe) chk("dout", dout, e_d);
   endtask
   task automatic tchk(input logic ext, input logic [12:0] a, input logic e_b,
         input logic [7:0] e_d);
      @(posedge clk_i);
      treq <= '{1'b1, ext, a};
      @(posedge clk_i);
      treq.req <= 1'b0;
      @(negedge clk_i);
      chk("valid", tvalid, 1'b1);
      chk("blocked", tblocked, e_b);
      chk("tdata", tdata, e_d);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_plain();
      logic [31:0] q;
      erase();
      vchk(1'b0, 13'h0005, 1'b1, 8'hFF);
      wb(1'b0, 8'h08, 32'h0, q);
      chk("unmapped", q, 32'h0);
      program_pulse_strobe.program_pulse_strobe(2'd0, 13'h0005, 8'h3C);
      vchk(1'b0, 13'h0005, 1'b1, 8'h3C);
      program_pulse_strobe.program_pulse_strobe(2'd0, 13'h0025, 8'h96);
      program_pulse_strobe.program_pulse_strobe(2'd1, 13'h0005, 8'h0F);
      vchk(1'b0, 13'h0005, 1'b1, 8'h3C ~^ 8'h0F);
      vchk(1'b0, 13'h0025, 1'b1, 8'h96 ~^ 8'h0F);
      vchk(1'b0, 13'h0024, 1'b1, 8'hFF);
      tchk(1'b1, 13'h0005, 1'b0, 8'h3C);
   endtask
   task automatic t_sig();
      vchk(1'b1, 13'h0030, 1'b1, MAKER);
      vchk(1'b1, 13'h0031, 1'b1, PART);
      vchk(1'b1, 13'h0032, 1'b1, 8'hFF);
   endtask
   task automatic t_lock1();
      logic [31:0] q;
      program_pulse_strobe.program_pulse_strobe(2'd2, 13'h0000, 8'h00);
      program_pulse_strobe.program_pulse_strobe(2'd0, 13'h0006, 8'h00);
      vchk(1'b0, 13'h0006, 1'b1, 8'hFF);
      wb(1'b0, `PLV_REG_STATUS, 32'h0, q);
      chk("reject", q[2], 1'b1);
      wb(1'b1, `PLV_REG_STATUS, 32'h4, q);
      wb(1'b0, `PLV_REG_STATUS, 32'h0, q);
      chk("reject clear", q[2], 1'b0);
      tchk(1'b1, 13'h0005, 1'b1, 8'hFF);
      tchk(1'b0, 13'h0005, 1'b0, 8'h3C);
      reset_dut(1'b1);
      ext_sel_n <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk("select held", ext_sel_o, 1'b1);
      wb(1'b0, `PLV_REG_STATUS, 32'h0, q);
      chk("select latch", q[1], 1'b1);
      @(posedge clk_i);
      ext_sel_n <= 1'b1;
   endtask
   task automatic t_lock2();
      program_pulse_strobe.program_pulse_strobe(2'd3, 13'h0000, 8'h00);
      vchk(1'b0, 13'h0005, 1'b0, 8'h00);
      vchk(1'b1, 13'h0030, 1'b1, MAKER);
      tchk(1'b1, 13'h0005, 1'b1, 8'hFF);
      erase();
      vchk(1'b0, 13'h0005, 1'b1, 8'hFF);
      tchk(1'b1, 13'h0005, 1'b0, 8'hFF);
      @(posedge clk_i);
      ext_sel_n <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk("select follows", ext_sel_o, 1'b0);
   endtask
   task automatic t_reserved();
      program_pulse_strobe.program_pulse_strobe(2'd3, 13'h0000, 8'h00);
      program_pulse_strobe.program_pulse_strobe(2'd0, 13'h0007, 8'h5A);
      vchk(1'b0, 13'h0007, 1'b1, 8'h5A);
      tchk(1'b1, 13'h0007, 1'b0, 8'h5A);
      erase();
   endtask
   task automatic conclude();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      conclude();
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_plain();
      t_sig();
      t_lock1();
      t_lock2();
      t_reserved();
      conclude();
   end
endmodule
bind program_lock_verify_guard plv_asserts #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE))
   assert_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .program_pulse_strobe_pins_i(program_pulse_strobe_pins_i), .data_port_o(data_port_o),
   .data_port_oe_o(data_port_oe_o), .table_req_i(table_req_i),
   .table_data_o(table_data_o), .table_valid_o(table_valid_o),
   .table_blocked_o(table_blocked_o));
`default_nettype wire
